// File: core/ldw_watchdog.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - mode register takes one write after reset; a second write resets
// - chip reset loads mode register with 67H: slow oscillator, longest period
// - clock select 00 slow oscillator, 01 system clock, 1x stopped
// - period n overflows after 2^(11+n) slow or 2^(13+n) system ticks
// - period field is all ones right after reset release
// - with oscillator locked, clock select writes ignored, slow source kept
// - a stopping first mode write suppresses resets from misuse
// - key ACH clears the counter and restarts counting
// - any other key byte causes an internal reset
// - single-bit access to the key register causes an internal reset
// - key register always reads 9AH
// - chip reset sets key register to 9AH
// - counter overflow asserts the internal reset
// - watchdog reset sets bit 4 of the reset-cause register
// - writing the mode register clears the counter
module ldw_watchdog #(
	parameter int SLOW_DIV_P = ldw_pkg::SLOW_DIV,
	parameter int SYS_DIV_P = ldw_pkg::SYS_DIV
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ldw_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic bitAccess,
	input wire logic oscLock,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic wdtReset,
	output logic irq
);
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pslverr_q, pslverr_d;
	logic wdtReset_q, irq_q;
	logic [7:0] mode_q, mode_d;
	logic modeWritten_q;
	logic lockCaught_q, lock_q;
	logic [ldw_pkg::COUNT_W-1:0] count_q;
	logic [ldw_pkg::ST_W-1:0] status_q, mask_q;
	logic causeFlag_q;
	logic [ldw_pkg::DIV_W-1:0] divCnt_q [2];
	logic tick_q [2];

	// bus decode
	wire [17:0] idx = paddr[ldw_pkg::ADDR_W-1:2];
	wire selMode = idx == ldw_pkg::MODE_IDX;
	wire selKey = idx == ldw_pkg::KEY_IDX;
	wire selStatus = idx == ldw_pkg::STATUS_IDX;
	wire selMask = idx == ldw_pkg::MASK_IDX;
	wire selCause = idx == ldw_pkg::CAUSE_IDX;
	wire selCount = idx == ldw_pkg::COUNT_IDX;
	wire mapped = selMode | selKey | selStatus | selMask | selCause | selCount;
	wire setup = psel & ~penable;
	wire access = psel & penable & pready_q;
	wire wrLane0 = access & pwrite & pstrb[0];
	wire modeWr = wrLane0 & selMode;
	wire keyWr = wrLane0 & selKey;
	// bit manipulation of the key register, read or write, counts as misuse
	wire keyBitOp = access & selKey & bitAccess;

	// mode decode
	wire stopped = mode_q[ldw_pkg::CLOCK_SEL_HI_BIT];
	wire sysSel = mode_q[ldw_pkg::CLOCK_SEL_LO_BIT];
	wire [2:0] period = mode_q[2:0];
	wire guardOff = stopped & modeWritten_q;

	wire badMode = modeWr & modeWritten_q & ~bitAccess & ~guardOff;
	wire badKey = keyWr & ~bitAccess & (pwdata[7:0] != ldw_pkg::KEY_RESTART)
		& ~guardOff;
	wire bitKey = keyBitOp & ~guardOff;
	wire goodKey = keyWr & ~bitAccess & (pwdata[7:0] == ldw_pkg::KEY_RESTART);
	// one accepted mode write; bit writes to mode are dropped
	wire firstMode = modeWr & ~modeWritten_q & ~bitAccess;

	// count source
	// source select
	wire countTick = stopped ? 1'b0 : (sysSel ? tick_q[1] : tick_q[0]);
	wire [4:0] expo = sysSel ? 5'(ldw_pkg::SYS_EXP_BASE + 32'(period))
		: 5'(ldw_pkg::SLOW_EXP_BASE + 32'(period));
	wire [ldw_pkg::COUNT_W-1:0] lastCount =
		(ldw_pkg::COUNT_W'(1) << expo) - ldw_pkg::COUNT_W'(1);
	wire clrCount = firstMode | goodKey;
	wire overflow = countTick & (count_q == lastCount) & ~clrCount;
	wire fire = overflow | badMode | badKey | bitKey;

	wire [ldw_pkg::ST_W-1:0] events = {bitKey, badKey, badMode, overflow};
	wire [ldw_pkg::ST_W-1:0] w1c = (access & pwrite & selStatus & pstrb[0])
		? pwdata[ldw_pkg::ST_W-1:0] : '0;

	wire [1:0] selWr = lock_q ? 2'b00 : pwdata[4:3];

	always_comb
	begin
		mode_d = {ldw_pkg::MODE_TOP_BITS, selWr, pwdata[2:0]};
		prdata_d = '0;
		pslverr_d = ~mapped;
		if (selMode)
			prdata_d[7:0] = mode_q;
		else if (selKey)
			prdata_d[7:0] = ldw_pkg::KEY_RESET;
		else if (selStatus)
			prdata_d[ldw_pkg::ST_W-1:0] = status_q;
		else if (selMask)
			prdata_d[ldw_pkg::ST_W-1:0] = mask_q;
		else if (selCause)
			prdata_d[ldw_pkg::CAUSE_FLAG_BIT] = causeFlag_q;
		else if (selCount)
			prdata_d[ldw_pkg::COUNT_W-1:0] = count_q;
	end

	// zero-wait slave: answer computed in setup, shown in access
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q <= setup;
			if (setup)
			begin
				prdata_q <= pwrite ? 32'h0 : prdata_d;
				pslverr_q <= pslverr_d;
			end
		end
	end

	// option strap caught after release
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lockCaught_q <= 1'b0;
			lock_q <= 1'b0;
		end
		else if (!lockCaught_q)
		begin
			lockCaught_q <= 1'b1;
			lock_q <= oscLock;
		end
	end

	// oscillator tick dividers
	localparam int DIVS [2] = '{SLOW_DIV_P, SYS_DIV_P};
	for (genvar g = 0; g < 2; g++)
	begin : gDiv
		wire divEnd = divCnt_q[g] == ldw_pkg::DIV_W'(DIVS[g] - 1);
		always_ff @(posedge ref_clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				divCnt_q[g] <= '0;
				tick_q[g] <= 1'b0;
			end
			else
			begin
				divCnt_q[g] <= divEnd ? '0 : divCnt_q[g] + 1'b1;
				tick_q[g] <= divEnd;
			end
		end
	end

	// internal reset reloads the mode register and clears the counter but keeps the status and mask flags and sets the cause flag
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q <= ldw_pkg::MODE_RESET;
			modeWritten_q <= 1'b0;
		end
		else if (fire)
		begin
			mode_q <= ldw_pkg::MODE_RESET;
			modeWritten_q <= 1'b0;
		end
		else if (firstMode)
		begin
			mode_q <= mode_d;
			modeWritten_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= '0;
		else if (fire | clrCount)
			count_q <= '0;
		else if (countTick)
			count_q <= count_q + 1'b1;
	end

	// sticky flags: a new event wins over a clear in the same cycle
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_q <= '0;
			mask_q <= '0;
			causeFlag_q <= 1'b0;
			wdtReset_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			status_q <= (status_q & ~w1c) | events;
			if (access & pwrite & selMask & pstrb[0])
				mask_q <= pwdata[ldw_pkg::ST_W-1:0];
			if (fire)
				causeFlag_q <= 1'b1;
			else if (access & pwrite & selCause & pstrb[0]
				& pwdata[ldw_pkg::CAUSE_FLAG_BIT])
				causeFlag_q <= 1'b0;
			wdtReset_q <= fire;
			irq_q <= |(((status_q & ~w1c) | events) & mask_q);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign wdtReset = wdtReset_q;
	assign irq = irq_q;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence keyReadSetup;
		setup & selKey & ~pwrite;
	endsequence
	sequence apbAccess;
		psel & penable & pready;
	endsequence

	AST_KEY_READBACK: assert property (
		keyReadSetup ##1 apbAccess |-> prdata[7:0] == 8'h9a)
		else $error("key register did not read 9a");
	AST_SECOND_MODE_WRITE: assert property (
		modeWr & modeWritten_q & ~bitAccess & ~stopped |=> wdtReset)
		else $error("second mode write did not reset");
	AST_STOPPED_SILENT: assert property (
		guardOff & ~overflow |=> ~wdtReset)
		else $error("reset despite stopped watchdog");
	AST_RESET_RELOAD: assert property (
		fire |=> mode_q == 8'h67 && !modeWritten_q && count_q == '0)
		else $error("internal reset did not reload mode");
	AST_GOOD_KEY: assert property (
		goodKey |=> count_q == '0 ##1 !wdtReset)
		else $error("restart key did not clear counter");
	AST_BAD_KEY: assert property (
		keyWr & ~bitAccess & pwdata[7:0] != 8'hac & ~guardOff |=> wdtReset)
		else $error("wrong key did not reset");
	AST_KEY_BIT_ACCESS: assert property (
		keyBitOp & ~guardOff |=> wdtReset)
		else $error("bit access to key did not reset");
	AST_OVERFLOW: assert property (
		countTick & count_q == lastCount & ~clrCount |=> wdtReset ##1 !wdtReset)
		else $error("overflow did not pulse reset");
	AST_CAUSE_FLAG: assert property (
		wdtReset |-> causeFlag_q)
		else $error("cause flag not set on watchdog reset");
	AST_LOCKED_SOURCE: assert property (
		lock_q |-> mode_q[4:3] == 2'b00)
		else $error("locked oscillator source changed");
	AST_MODE_CLEARS: assert property (
		firstMode & ~fire |=> count_q == '0 && mode_q[7:5] == 3'b011)
		else $error("mode write did not clear counter");
	AST_STEP: assert property (
		countTick & ~clrCount & ~fire |=> count_q == $past(count_q) + 1'b1)
		else $error("counter did not step on tick");
endmodule

`default_nettype wire

// File: core/ldw_pkg.sv
`default_nettype none
package ldw_pkg;
	// register indices; byte address is four times the index
	localparam logic [17:0] MODE_IDX = 18'h0ff48;
	localparam logic [17:0] KEY_IDX = 18'h0ff49;
	localparam logic [17:0] STATUS_IDX = 18'h0ff4a;
	localparam logic [17:0] MASK_IDX = 18'h0ff4b;
	localparam logic [17:0] CAUSE_IDX = 18'h0ff4c;
	localparam logic [17:0] COUNT_IDX = 18'h0ff4d;
	localparam int ADDR_W = 20;

	localparam logic [7:0] MODE_RESET = 8'h67;
	localparam logic [2:0] MODE_TOP_BITS = 3'h3;
	localparam logic [7:0] KEY_RESET = 8'h9a;
	localparam logic [7:0] KEY_RESTART = 8'hac;
	localparam int CLOCK_SEL_HI_BIT = 4;
	localparam int CLOCK_SEL_LO_BIT = 3;
	localparam int CAUSE_FLAG_BIT = 4;

	// overflow exponent base per count source
	localparam int SLOW_EXP_BASE = 11;
	localparam int SYS_EXP_BASE = 13;
	localparam int COUNT_W = 21;

	// status bits
	localparam int ST_OVERFLOW = 0;
	localparam int ST_BAD_MODE = 1;
	localparam int ST_BAD_KEY = 2;
	localparam int ST_BIT_ACCESS = 3;
	localparam int ST_W = 4;

	// oscillator rates, derived divider counts (rounded down)
	localparam int REF_CLK_KHZ = 250000;
	localparam int SLOW_OSC_KHZ = 480;
	localparam int SYS_OSC_KHZ = 10000;
	localparam int SLOW_DIV = REF_CLK_KHZ / SLOW_OSC_KHZ;
	localparam int SYS_DIV = REF_CLK_KHZ / SYS_OSC_KHZ;
	localparam int DIV_W = 12;
endpackage
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ldw_pkg::ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h1;
	logic bitAccess = 1'b0;
	logic oscLock = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, wdtReset, irq;
	logic [31:0] rdv;
	logic errv;
	logic [31:0] held;
	int n_errors = 0;
	int samples_checked = 0;
	int pulses = 0;
	int cycles = 0;

	// short dividers keep overflow runs to a few thousand cycles
	ldw_watchdog #(.SLOW_DIV_P(2), .SYS_DIV_P(1)) uut (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.bitAccess(bitAccess), .oscLock(oscLock), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wdtReset(wdtReset), .irq(irq)
	);

	initial forever #2 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (wdtReset === 1'b1)
			pulses <= pulses + 1;
		if (cycles == 40000)
		begin
			n_errors++;
			test_done();
		end
	end

	task test_done;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; held until pready is seen high
	task xfer(input logic w, input logic [17:0] idx, input logic [7:0] d,
		input logic b);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		bitAccess <= b;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		bitAccess <= 1'b0;
	endtask

	task wr(input logic [17:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d, 1'b0);
	endtask

	task rd(input logic [17:0] idx, input logic [31:0] exp, input string what);
		xfer(1'b0, idx, 8'h0, 1'b0);
		chk(what, exp, rdv);
	endtask

	task pulse(input int lo, input int hi, input string what);
		int n0;
		int c;
		n0 = pulses;
		c = 0;
		while (pulses == n0 && c <= hi)
		begin
			@(posedge ref_clk);
			c++;
		end
		chk(what, 32'h1, 32'(c >= lo && c <= hi));
	endtask

	task quiet(input string what);
		int n0;
		n0 = pulses;
		repeat (6) @(posedge ref_clk);
		chk(what, 32'(n0), 32'(pulses));
	endtask

	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(ldw_pkg::MODE_IDX, 32'h67, "mode reset"); // default
		rd(ldw_pkg::KEY_IDX, 32'h9a, "key reset"); // default
		xfer(1'b0, 18'h0ff50, 8'h0, 1'b0);
		chk("unmapped err", 32'h1, 32'(errv));
		// let the count climb well past the bound so a lost restart shows
		repeat (100) @(posedge ref_clk);
		wr(ldw_pkg::KEY_IDX, 8'hac); // restart key
		xfer(1'b0, ldw_pkg::COUNT_IDX, 8'h0, 1'b0);
		chk("count restart", 32'h1, 32'(rdv < 16)); // cleared
		rd(ldw_pkg::KEY_IDX, 32'h9a, "key read"); // fixed read
		quiet("good key"); // no reset
		wr(ldw_pkg::MASK_IDX, 8'h04);
		wr(ldw_pkg::KEY_IDX, 8'h55); // wrong key
		pulse(1, 6, "bad key"); // reset
		rd(ldw_pkg::CAUSE_IDX, 32'h10, "cause"); // flag bit
		rd(ldw_pkg::STATUS_IDX, 32'h4, "status");
		chk("irq set", 32'h1, 32'(irq));
		wr(ldw_pkg::STATUS_IDX, 8'h04);
		wr(ldw_pkg::CAUSE_IDX, 8'h10);
		rd(ldw_pkg::CAUSE_IDX, 32'h0, "cause clear");
		chk("irq clear", 32'h0, 32'(irq));
		xfer(1'b1, ldw_pkg::KEY_IDX, 8'hac, 1'b1); // bit access
		pulse(1, 6, "bit access"); // reset
		wr(ldw_pkg::MODE_IDX, 8'h68); // 011 top, byte write
		rd(ldw_pkg::MODE_IDX, 32'h68, "mode sys"); // source
		pulse(8180, 8200, "sys overflow");
		rd(ldw_pkg::MODE_IDX, 32'h67, "mode reload"); // reload
		wr(ldw_pkg::MODE_IDX, 8'h60); // shortest slow
		pulse(4080, 4110, "slow overflow"); // timing
		repeat (200) @(posedge ref_clk);
		wr(ldw_pkg::MODE_IDX, 8'h67); // longest period
		xfer(1'b0, ldw_pkg::COUNT_IDX, 8'h0, 1'b0);
		chk("count mode", 32'h1, 32'(rdv < 16)); // cleared
		wr(ldw_pkg::MODE_IDX, 8'h67); // second write
		pulse(1, 6, "second mode"); // write once
		wr(ldw_pkg::MODE_IDX, 8'h70); // stop
		xfer(1'b0, ldw_pkg::COUNT_IDX, 8'h0, 1'b0);
		held = rdv;
		repeat (50) @(posedge ref_clk);
		rd(ldw_pkg::COUNT_IDX, held, "count stopped"); // stopped
		// the first two misuse resets would land before quiet starts, so count from here
		held = 32'(pulses);
		wr(ldw_pkg::MODE_IDX, 8'h63); // second write
		wr(ldw_pkg::KEY_IDX, 8'h55); // wrong key
		xfer(1'b1, ldw_pkg::KEY_IDX, 8'hac, 1'b1); // bit access
		quiet("stopped misuse"); // suppressed
		chk("stopped resets", held, 32'(pulses)); // none at all
		rd(ldw_pkg::MODE_IDX, 32'h70, "mode kept"); // ignored
		// strap is caught at the first edge after release
		oscLock <= 1'b1;
		rst_n <= 1'b0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		wr(ldw_pkg::MODE_IDX, 8'h68); // select ignored
		rd(ldw_pkg::MODE_IDX, 32'h60, "mode locked"); // forced slow
		pulse(4080, 4110, "locked overflow"); // slow source
		test_done();
	end
endmodule
`default_nettype wire
